// File: pkg/dwd_defines.svh
`ifndef DWD_DEFINES_SVH
`define DWD_DEFINES_SVH

// Default overflow counts of the two channels, in CLOCK cycles.
`define DWD_FIRST_DEFAULT_COUNT 32'h0001_0000
`define DWD_SECOND_DEFAULT_COUNT 32'h0004_0000
// Default oscillation stabilization wait, in CLOCK cycles.
`define DWD_STAB_DEFAULT_COUNT 32'h0000_4000
// Width of each channel's counter.
`define DWD_COUNT_WIDTH 32

`endif

// File: pkg/dwd_pkg.sv
package dwd_pkg;
  // Operating roles of the first channel.
  typedef enum logic [1:0] {
    DWD_MODE_WATCHDOG,
    DWD_MODE_INTERVAL,
    DWD_MODE_STABILIZE
  } dwd_mode_t;

  // Overflow response of a watchdog channel.
  typedef enum logic {
    DWD_RESP_NMI,
    DWD_RESP_RESET
  } dwd_resp_t;

  // Requests a channel raises toward the interrupt controller and reset logic.
  typedef struct packed {
    logic nmi;
    logic rst;
    logic irq;
  } dwd_req_t;
endpackage

// File: rtl/dwd_channel.sv
`timescale 1ns/100ps
`include "dwd_defines.svh"

// One free-running overflow counter with restart and enable.
// Emits a one-cycle overflow pulse and reloads from zero, so interval use repeats.
module dwd_channel #(
  parameter int WIDTH = `DWD_COUNT_WIDTH
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic enable,
  input wire logic restart,
  input wire logic [WIDTH-1:0] limit,
  output logic overflow,
  output logic [WIDTH-1:0] count
);
  // Restart wins over counting; a stopped channel holds its value.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      count <= '0;
      overflow <= 1'b0;
    end else if (restart || !enable) begin
      count <= restart ? '0 : count;
      overflow <= 1'b0;
    end else if (count >= limit - WIDTH'(1)) begin
      count <= '0;
      overflow <= 1'b1;
    end else begin
      count <= count + WIDTH'(1);
      overflow <= 1'b0;
    end
  end
endmodule

// File: rtl/dwd_watchdogs.sv
`timescale 1ns/100ps
`include "dwd_defines.svh"

// Behaviour
// - Two independent counters each overflow unless software restarts them, flagging a runaway.
// - In watchdog mode the first channel's overflow raises its NMI or its reset request.
// - In interval mode each first-channel overflow raises only its maskable interrupt.
// - The first channel can time the oscillation stabilization wait before operation resumes.
// - The second channel counts from reset release with no software action.
// - The second channel's overflow raises its NMI or its reset request as selected.
module dwd_watchdogs #(
  parameter int WIDTH = `DWD_COUNT_WIDTH,
  parameter logic [WIDTH-1:0] FIRST_DEFAULT = WIDTH'(`DWD_FIRST_DEFAULT_COUNT),
  parameter logic [WIDTH-1:0] SECOND_DEFAULT = WIDTH'(`DWD_SECOND_DEFAULT_COUNT),
  parameter logic [WIDTH-1:0] STAB_DEFAULT = WIDTH'(`DWD_STAB_DEFAULT_COUNT)
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic FIRST_ENABLE,
  input wire dwd_pkg::dwd_mode_t FIRST_MODE,
  input wire dwd_pkg::dwd_resp_t FIRST_RESPONSE,
  input wire logic [WIDTH-1:0] FIRST_LIMIT,
  input wire logic FIRST_RESTART,
  input wire logic STAB_START,
  input wire logic SECOND_STOP,
  input wire dwd_pkg::dwd_resp_t SECOND_RESPONSE,
  input wire logic [WIDTH-1:0] SECOND_LIMIT,
  input wire logic SECOND_RESTART,
  output dwd_pkg::dwd_req_t FIRST_REQ,
  output dwd_pkg::dwd_req_t SECOND_REQ,
  output logic STAB_DONE,
  output logic STAB_BUSY
);
  import dwd_pkg::*;

  // Internal overflow pulses, counts and the selected limits of both channels.
  logic first_ovf;
  logic second_ovf;
  logic [WIDTH-1:0] first_count;
  logic [WIDTH-1:0] second_count;
  logic [WIDTH-1:0] first_limit;
  logic [WIDTH-1:0] second_limit;
  logic first_run;
  logic first_restart;

  // A limit of zero selects the default, so an unconfigured chip still has protection.
  function automatic logic [WIDTH-1:0] pick_limit(input logic [WIDTH-1:0] req,
                                                   input logic [WIDTH-1:0] dflt);
    pick_limit = (req == '0) ? dflt : req;
  endfunction

  // The stabilization wait uses its own default when no limit is given.
  always_comb begin
    first_limit = pick_limit(FIRST_LIMIT,
                             (FIRST_MODE == DWD_MODE_STABILIZE) ? STAB_DEFAULT : FIRST_DEFAULT);
    second_limit = pick_limit(SECOND_LIMIT, SECOND_DEFAULT);
    first_run = STAB_BUSY || (FIRST_ENABLE && FIRST_MODE != DWD_MODE_STABILIZE);
    first_restart = FIRST_RESTART || STAB_START;
  end

  // First channel counter.
  dwd_channel #(.WIDTH(WIDTH)) u_first (
    .clock(CLOCK),
    .resetn(RESETN),
    .enable(first_run),
    .restart(first_restart),
    .limit(first_limit),
    .overflow(first_ovf),
    .count(first_count)
  );

  // Second channel counter; it runs from reset unless explicitly stopped.
  dwd_channel #(.WIDTH(WIDTH)) u_second (
    .clock(CLOCK),
    .resetn(RESETN),
    .enable(!SECOND_STOP),
    .restart(SECOND_RESTART),
    .limit(second_limit),
    .overflow(second_ovf),
    .count(second_count)
  );

  // Stabilization wait: busy from start until the first overflow, then a done pulse.
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      STAB_BUSY <= 1'b0;
      STAB_DONE <= 1'b0;
    end else begin
      STAB_DONE <= 1'b0;
      if (STAB_START && FIRST_MODE == DWD_MODE_STABILIZE) begin
        STAB_BUSY <= 1'b1;
      end else if (STAB_BUSY && first_ovf) begin
        STAB_BUSY <= 1'b0;
        STAB_DONE <= 1'b1;
      end
    end
  end

  // First channel requests, one-cycle pulses steered by mode and response.
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      FIRST_REQ <= '0;
    end else begin
      FIRST_REQ.nmi <= first_ovf && FIRST_MODE == DWD_MODE_WATCHDOG
                       && FIRST_RESPONSE == DWD_RESP_NMI;
      FIRST_REQ.rst <= first_ovf && FIRST_MODE == DWD_MODE_WATCHDOG
                       && FIRST_RESPONSE == DWD_RESP_RESET;
      FIRST_REQ.irq <= first_ovf && FIRST_MODE == DWD_MODE_INTERVAL;
    end
  end

  // Second channel requests; it has no maskable interrupt.
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      SECOND_REQ <= '0;
    end else begin
      SECOND_REQ.nmi <= second_ovf && SECOND_RESPONSE == DWD_RESP_NMI;
      SECOND_REQ.rst <= second_ovf && SECOND_RESPONSE == DWD_RESP_RESET;
      SECOND_REQ.irq <= 1'b0;
    end
  end

  // A watchdog-mode overflow of the first channel is never lost.
  property p_first_wd;
    @(posedge CLOCK) disable iff (!RESETN)
      first_ovf && FIRST_MODE == DWD_MODE_WATCHDOG |=> (FIRST_REQ.nmi || FIRST_REQ.rst);
  endproperty
  a_first_wd: assert property (p_first_wd) else $error("first watchdog overflow lost");

  // An interval overflow raises the maskable interrupt and nothing else.
  property p_first_iv;
    @(posedge CLOCK) disable iff (!RESETN)
      first_ovf && FIRST_MODE == DWD_MODE_INTERVAL |=> FIRST_REQ.irq && !FIRST_REQ.nmi
      && !FIRST_REQ.rst;
  endproperty
  a_first_iv: assert property (p_first_iv) else $error("interval overflow wrong request");

  // The maskable interrupt never appears without an overflow behind it.
  property p_irq_cause;
    @(posedge CLOCK) disable iff (!RESETN)
      FIRST_REQ.irq |-> $past(first_ovf);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interval irq without overflow");

  // The end of the wait is marked once and releases the busy flag.
  property p_stab;
    @(posedge CLOCK) disable iff (!RESETN)
      STAB_BUSY && first_ovf && !STAB_START |=> STAB_DONE && !STAB_BUSY;
  endproperty
  a_stab: assert property (p_stab) else $error("stabilization end missed");

  // The second channel counts on its own once reset is released.
  property p_second_runs;
    @(posedge CLOCK) disable iff (!RESETN)
      !SECOND_STOP && !SECOND_RESTART && !second_ovf && second_count < second_limit - WIDTH'(1)
      |=> second_count == $past(second_count) + WIDTH'(1);
  endproperty
  a_second_runs: assert property (p_second_runs) else $error("second channel not counting");

  // Every second-channel overflow leaves exactly one request.
  property p_second_req;
    @(posedge CLOCK) disable iff (!RESETN)
      second_ovf |=> (SECOND_REQ.nmi != SECOND_REQ.rst);
  endproperty
  a_second_req: assert property (p_second_req) else $error("second overflow lost");

  // A second-channel request always has an overflow behind it.
  property p_second_cause;
    @(posedge CLOCK) disable iff (!RESETN)
      (SECOND_REQ.nmi || SECOND_REQ.rst) |-> $past(second_ovf);
  endproperty
  a_second_cause: assert property (p_second_cause) else $error("second request uncaused");

  // A restart clears the count and holds off an overflow in the same cycle.
  property p_restart;
    @(posedge CLOCK) disable iff (!RESETN)
      SECOND_RESTART |=> second_count == '0 && !second_ovf;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not clear counter");

  // Watchdog requests of the first channel only ever follow its own overflow.
  property p_first_cause;
    @(posedge CLOCK) disable iff (!RESETN)
      (FIRST_REQ.nmi || FIRST_REQ.rst) |-> $past(first_ovf);
  endproperty
  a_first_cause: assert property (p_first_cause) else $error("first request uncaused");

  // At most one request line of the first channel is high in any cycle.
  property p_first_onehot;
    @(posedge CLOCK) disable iff (!RESETN)
      $onehot0({FIRST_REQ.nmi, FIRST_REQ.rst, FIRST_REQ.irq});
  endproperty
  a_first_onehot: assert property (p_first_onehot) else $error("first requests overlap");

  // The second channel has no maskable interrupt and never raises both of its requests.
  property p_second_only;
    @(posedge CLOCK) disable iff (!RESETN)
      !SECOND_REQ.irq && !(SECOND_REQ.nmi && SECOND_REQ.rst);
  endproperty
  a_second_only: assert property (p_second_only) else $error("second request malformed");

  // While the first channel times the stabilization wait it raises no request at all.
  property p_stab_quiet;
    @(posedge CLOCK) disable iff (!RESETN)
      FIRST_MODE == DWD_MODE_STABILIZE |=> FIRST_REQ == '0;
  endproperty
  a_stab_quiet: assert property (p_stab_quiet) else $error("request during wait");

  // A start in stabilize mode marks the wait busy and begins it from a cleared count.
  property p_stab_start;
    @(posedge CLOCK) disable iff (!RESETN)
      STAB_START && FIRST_MODE == DWD_MODE_STABILIZE |=> STAB_BUSY && first_count == '0;
  endproperty
  a_stab_start: assert property (p_stab_start) else $error("start not taken");

  // The done marker is a single-cycle pulse, so a waiting sequencer sees it once.
  property p_done_pulse;
    @(posedge CLOCK) disable iff (!RESETN)
      STAB_DONE |=> !STAB_DONE;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done held too long");

  // A running first channel advances by one each cycle until it reaches one below its limit.
  property p_first_runs;
    @(posedge CLOCK) disable iff (!RESETN)
      first_run && !first_restart && first_count < first_limit - WIDTH'(1)
      |=> first_count == $past(first_count) + WIDTH'(1);
  endproperty
  a_first_runs: assert property (p_first_runs) else $error("first channel not counting");

  // A stopped second channel holds its count, so stopping loses no progress.
  property p_second_hold;
    @(posedge CLOCK) disable iff (!RESETN)
      SECOND_STOP && !SECOND_RESTART |=> second_count == $past(second_count);
  endproperty
  a_second_hold: assert property (p_second_hold) else $error("stopped count moved");
endmodule

// File: tb/test_dual_watchdog_timers.sv
`timescale 1ns/100ps

module test_dual_watchdog_timers;
  import dwd_pkg::*;
  localparam int L = 8;
  // Defaults differ from L and from each other, so the fallback choice is visible.
  localparam int FD = 12, SD = 10, SB = 14;
  logic clock = 0, resetn = 0, f_en = 0, f_rst = 0, stab_go = 0, s_stop = 0, s_rst = 0;
  logic [7:0] f_lim = 8'h08, s_lim = 8'h08;
  dwd_mode_t f_mode = DWD_MODE_WATCHDOG;
  dwd_resp_t f_resp = DWD_RESP_NMI, s_resp = DWD_RESP_NMI;
  dwd_req_t f_req, s_req;
  logic stab_done, stab_busy;
  int n_mismatch = 0, compares = 0;

  // Free-running 40 MHz clock.
  always #12.5 clock = ~clock;

  // Short limits and defaults keep every overflow within a few dozen cycles.
  dwd_watchdogs #(.WIDTH(8), .FIRST_DEFAULT(8'(FD)), .SECOND_DEFAULT(8'(SD)),
    .STAB_DEFAULT(8'(SB))) dwd_watchdogs_i (.CLOCK(clock), .RESETN(resetn),
    .FIRST_ENABLE(f_en), .FIRST_MODE(f_mode), .FIRST_RESPONSE(f_resp),
    .FIRST_LIMIT(f_lim), .FIRST_RESTART(f_rst), .STAB_START(stab_go),
    .SECOND_STOP(s_stop), .SECOND_RESPONSE(s_resp), .SECOND_LIMIT(s_lim),
    .SECOND_RESTART(s_rst), .FIRST_REQ(f_req), .SECOND_REQ(s_req),
    .STAB_DONE(stab_done), .STAB_BUSY(stab_busy));

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(int k);
    repeat (k) @(posedge clock);
    #2;
  endtask

  // Waits a bounded time for a request; an unknown ends the wait so the compare sees it.
  task automatic wait_req(logic sel, output logic [7:0] r, output int n);
    n = 0;
    r = 8'h00;
    while (n < 40 && r === 8'h00) begin
      tick(1);
      n++;
      r = 8'(sel ? s_req : f_req);
    end
  endtask

  task automatic kick(logic sel);
    if (sel) s_rst = 1;
    else f_rst = 1;
    tick(1);
    s_rst = 0;
    f_rst = 0;
  endtask

  task automatic t_boot;
    logic [7:0] r;
    int n;
    wait_req(1, r, n);
    s_stop = 1;
    chk("boot request", 8'h04, r);
    chk("boot delay", 8'(L + 1), 8'(n));
  endtask

  // The request follows the restart by the limit plus one registered stage.
  // Interval overflows then repeat every limit cycles, since the counter reloads from zero.
  task automatic t_first(dwd_mode_t m, dwd_resp_t p, logic [7:0] exp);
    logic [7:0] r;
    int n;
    f_mode = m;
    f_resp = p;
    f_en = 1;
    kick(0);
    wait_req(0, r, n);
    chk("first request", exp, r);
    chk("first delay", 8'(L + 1), 8'(n));
    if (m == DWD_MODE_INTERVAL) begin
      wait_req(0, r, n);
      chk("interval repeat", exp, r);
      chk("interval period", 8'(L), 8'(n));
    end
    f_en = 0;
    tick(1);
  endtask

  task automatic t_second(dwd_resp_t p, logic [7:0] exp);
    logic [7:0] r;
    int n;
    s_resp = p;
    s_stop = 0;
    kick(1);
    wait_req(1, r, n);
    chk("second request", exp, r);
    chk("second delay", 8'(L + 1), 8'(n));
    s_stop = 1;
    tick(1);
  endtask

  // Restarting both channels every five cycles, out of phase, must hold every request low.
  task automatic t_restart;
    f_mode = DWD_MODE_WATCHDOG;
    f_en = 1;
    s_stop = 0;
    repeat (8) begin
      kick(0);
      for (int i = 0; i < L / 2; i++) begin
        chk("restarted quiet", 8'h00, 8'({f_req, s_req}));
        if (i == 1) s_rst = 1;
        if (i == 2) s_rst = 0;
        tick(1);
      end
    end
    f_en = 0;
    s_stop = 1;
  endtask

  task automatic t_stab;
    int n;
    stab_go = 1;
    tick(1);
    stab_go = 0;
    tick(2);
    chk("start ignored", 8'h00, 8'(stab_busy));
    f_mode = DWD_MODE_STABILIZE;
    f_lim = 8'h00;
    stab_go = 1;
    tick(1);
    stab_go = 0;
    tick(1);
    chk("stab busy", 8'h01, 8'(stab_busy));
    n = 0;
    while (n < 40 && stab_done !== 1'b1) begin
      tick(1);
      n++;
    end
    chk("stab done", 8'h01, 8'(stab_done));
    chk("stab wait", 8'(SB), 8'(n));
    chk("stab no request", 8'h00, 8'(f_req));
    tick(2);
    chk("stab idle", 8'h00, 8'(stab_busy));
  endtask

  // A zero limit falls back to each channel's default overflow count.
  task automatic t_default;
    logic [7:0] r;
    int n;
    f_lim = 8'h00;
    s_lim = 8'h00;
    f_mode = DWD_MODE_WATCHDOG;
    f_resp = DWD_RESP_RESET;
    f_en = 1;
    kick(0);
    wait_req(0, r, n);
    f_en = 0;
    chk("first default request", 8'h02, r);
    chk("first default delay", 8'(FD + 1), 8'(n));
    s_resp = DWD_RESP_NMI;
    s_stop = 0;
    kick(1);
    wait_req(1, r, n);
    s_stop = 1;
    chk("second default request", 8'h04, r);
    chk("second default delay", 8'(SD + 1), 8'(n));
    f_lim = 8'h08;
    s_lim = 8'h08;
  endtask

  // A reset in mid-run clears every output, and the second channel then starts over by itself.
  task automatic t_rerun;
    resetn = 0;
    tick(2);
    chk("reset quiet", 8'h00, 8'({f_req, s_req, stab_done, stab_busy}));
    s_stop = 0;
    resetn = 1;
    t_boot;
  endtask

  task automatic close_out;
    $display("Mismatches %0d of %0d compares", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence after ten cycles of reset.
  initial begin
    tick(10);
    resetn = 1;
    t_boot;
    t_first(DWD_MODE_WATCHDOG, DWD_RESP_NMI, 8'h04);
    t_first(DWD_MODE_WATCHDOG, DWD_RESP_RESET, 8'h02);
    t_first(DWD_MODE_INTERVAL, DWD_RESP_NMI, 8'h01);
    t_second(DWD_RESP_NMI, 8'h04);
    t_second(DWD_RESP_RESET, 8'h02);
    t_restart;
    t_stab;
    t_default;
    t_rerun;
    close_out;
  end

  // The whole run takes well under 1000 cycles, so this only cuts a hang short.
  initial begin
    #100000;
    n_mismatch++;
    close_out;
  end
endmodule
